// ---- hpw_host_model.sv ----
/*
 * Host model: I2C master doing one-byte register writes and reads.
 * Assumes the bench resolves open-drain SDA with a pull-up.
 */
`timescale 1ns/1ns

module hpw_host_model #(
	parameter int HALF = 8
) (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Data moves only while SCL is low; no clock stretching
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		repeat (HALF / 2) @(posedge mclk);
		sda_low <= !b;
		repeat (HALF / 2) @(posedge mclk);
		scl <= 1'b1;
		repeat (HALF) @(posedge mclk);
		r = sda;
	endtask

	task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		// Released: target acks a write, host nacks a read
		bit_io(1'b1, r);
	endtask

	task automatic start_c();
		sda_low <= 1'b1;
		repeat (HALF) @(posedge mclk);
	endtask

	task automatic stop_c();
		scl <= 1'b0;
		repeat (HALF / 2) @(posedge mclk);
		sda_low <= 1'b1;
		repeat (HALF / 2) @(posedge mclk);
		scl <= 1'b1;
		repeat (HALF) @(posedge mclk);
		sda_low <= 1'b0;
		repeat (HALF) @(posedge mclk);
	endtask

	task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start_c();
		byte_io({dev, 1'b0}, q);
		byte_io(a, q);
		byte_io(d, q);
		stop_c();
	endtask

	task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
		logic [7:0] q;
		start_c();
		byte_io({dev, 1'b0}, q);
		byte_io(a, q);
		stop_c();
		start_c();
		byte_io({dev, 1'b1}, q);
		byte_io(8'hFF, d);
		stop_c();
	endtask
endmodule

// ---- hpw_i2c_target.sv ----
/*
 * I2C target: address match, register pointer, write strobes and read bursts.
 * Assumes raw scl/sda pin levels; sda is open drain, oe high pulls it low.
 */
`timescale 1ns/1ns

module hpw_i2c_target (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	input  wire logic [6:0]       my_addr,
	input  wire logic [7:0]       rd_data,
	output hpw_pkg::hpw_wr_t      wr,
	output hpw_pkg::hpw_rd_t      rd,
	output logic                  sda_oe
);

	typedef enum logic [3:0] {
		HPW_I_IDLE, HPW_I_ADDR, HPW_I_ACK_A, HPW_I_PTR, HPW_I_ACK_P,
		HPW_I_WDATA, HPW_I_ACK_W, HPW_I_RDATA, HPW_I_RACK
	} hpw_i2c_st_t;

	typedef struct packed {
		logic [2:0]       scl_sync;
		logic [2:0]       sda_sync;
		hpw_i2c_st_t      st;
		logic [2:0]       bitn;
		logic [7:0]       sh;
		logic             rnw;
		logic             acked;
		logic             oe;
		logic [7:0]       ptr;
		hpw_pkg::hpw_rd_t rd;
		hpw_pkg::hpw_wr_t wr;
	} hpw_i2c_state_t;

	hpw_i2c_state_t s_ff;
	hpw_i2c_state_t nxt_s;

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic sda_v;

	// Edges read only stages 2 and 3; stage 1 feeds stage 2 alone
	assign sda_v    = s_ff.sda_sync[1];
	assign scl_rise = s_ff.scl_sync[1] & ~s_ff.scl_sync[2];
	assign scl_fall = ~s_ff.scl_sync[1] & s_ff.scl_sync[2];
	assign start_c  = s_ff.scl_sync[1] & s_ff.scl_sync[2] & ~sda_v & s_ff.sda_sync[2];
	assign stop_c   = s_ff.scl_sync[1] & s_ff.scl_sync[2] & sda_v & ~s_ff.sda_sync[2];

	always_comb begin
		nxt_s          = s_ff;
		nxt_s.scl_sync = {s_ff.scl_sync[1:0], scl_in};
		nxt_s.sda_sync = {s_ff.sda_sync[1:0], sda_in};
		nxt_s.wr.stb   = 1'b0;
		if (start_c) begin
			nxt_s.st   = HPW_I_ADDR;
			nxt_s.bitn = 3'd0;
			nxt_s.oe   = 1'b0;
		end else if (stop_c) begin
			nxt_s.st = HPW_I_IDLE;
			nxt_s.oe = 1'b0;
		end else begin
			case (s_ff.st)
			HPW_I_ADDR, HPW_I_PTR, HPW_I_WDATA: begin
				if (scl_rise) begin
					nxt_s.sh   = {s_ff.sh[6:0], sda_v};
					nxt_s.bitn = s_ff.bitn + 3'd1;
					nxt_s.acked = 1'b0;
					if (s_ff.bitn == 3'd7) begin
						case (s_ff.st)
						HPW_I_ADDR: begin
							// R12
							if (s_ff.sh[6:0] == my_addr) begin
								nxt_s.rnw = sda_v;
								nxt_s.st  = HPW_I_ACK_A;
							end else begin
								nxt_s.st = HPW_I_IDLE;
							end
						end
						HPW_I_PTR: begin
							nxt_s.ptr = {s_ff.sh[6:0], sda_v};
							nxt_s.st  = HPW_I_ACK_P;
						end
						default: begin
							// R16
							nxt_s.wr.stb  = 1'b1;
							nxt_s.wr.addr = s_ff.ptr;
							nxt_s.wr.data = {s_ff.sh[6:0], sda_v};
							nxt_s.ptr     = s_ff.ptr + 8'd1;
							nxt_s.st      = HPW_I_ACK_W;
						end
						endcase
					end
				end
			end
			HPW_I_ACK_A, HPW_I_ACK_P, HPW_I_ACK_W: begin
				if (scl_fall) begin
					if (!s_ff.acked) begin
						nxt_s.oe    = 1'b1;
						nxt_s.acked = 1'b1;
						// Read start latched a whole bit early so rd_data has settled
						nxt_s.rd.base = s_ff.ptr;
						nxt_s.rd.idx  = 8'd0;
					end else if (s_ff.st == HPW_I_ACK_A && s_ff.rnw) begin
						nxt_s.rd.base = s_ff.ptr;
						nxt_s.rd.idx  = 8'd0;
						nxt_s.sh      = rd_data;
						nxt_s.oe      = ~rd_data[7];
						nxt_s.bitn    = 3'd0;
						nxt_s.st      = HPW_I_RDATA;
					end else begin
						nxt_s.oe   = 1'b0;
						nxt_s.bitn = 3'd0;
						nxt_s.st   = (s_ff.st == HPW_I_ACK_A) ? HPW_I_PTR : HPW_I_WDATA;
					end
				end
			end
			HPW_I_RDATA: begin
				if (scl_fall) begin
					nxt_s.bitn = s_ff.bitn + 3'd1;
					if (s_ff.bitn == 3'd7) begin
						nxt_s.oe = 1'b0;
						nxt_s.st = HPW_I_RACK;
					end else begin
						nxt_s.sh = {s_ff.sh[6:0], 1'b0};
						nxt_s.oe = ~s_ff.sh[6];
					end
				end
			end
			HPW_I_RACK: begin
				if (scl_rise) begin
					// Master nack ends the burst
					if (sda_v) begin
						nxt_s.st = HPW_I_IDLE;
					end else begin
						nxt_s.rd.idx = s_ff.rd.idx + 8'd1;
						nxt_s.acked  = 1'b1;
					end
				end else if (scl_fall && s_ff.acked) begin
					nxt_s.acked = 1'b0;
					nxt_s.sh    = rd_data;
					nxt_s.oe    = ~rd_data[7];
					nxt_s.bitn  = 3'd0;
					nxt_s.st    = HPW_I_RDATA;
				end
			end
			default: begin
				nxt_s.oe = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_ff          <= '0;
			s_ff.scl_sync <= 3'b111;
			s_ff.sda_sync <= 3'b111;
			s_ff.st       <= HPW_I_IDLE;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign wr     = s_ff.wr;
	assign rd     = s_ff.rd;
	assign sda_oe = s_ff.oe;

endmodule

// ---- hpw_pkg.sv ----
/*
 * Shared constants and carrier types for the host power watchdog controller.
 * Assumes a single 125 MHz clock domain and a host that acts as I2C master.
 */
package hpw_pkg;

	// ------------------------------------------------------------
	// Register and command locations
	// ------------------------------------------------------------
	localparam logic [7:0] REG_FAN_MGMT       = 8'h30;
	localparam logic [7:0] REG_REMOTE_SD      = 8'h32;
	localparam logic [7:0] REG_REMOTE_DETECT  = 8'h33;
	localparam logic [7:0] REG_PWR_RESTORE    = 8'h34;
	localparam logic [7:0] REG_WD_CTRL        = 8'h35;
	localparam logic [7:0] REG_WD_TIMEOUT     = 8'h36;
	localparam logic [7:0] REG_WD_REBOOT      = 8'h37;
	localparam logic [7:0] REG_WD_POWER_OFF   = 8'h38;
	localparam logic [7:0] REG_BUS_ADDR       = 8'h39;
	localparam logic [7:0] CMD_RESET_DEFAULTS = 8'h80;
	localparam logic [7:0] CMD_RESERVED       = 8'h81;
	localparam logic [7:0] CMD_KEEP_ALIVE     = 8'h82;
	localparam logic [7:0] CMD_ALIVE          = 8'h83;
	localparam logic [7:0] CMD_FAN0_SPEED     = 8'h84;
	localparam logic [7:0] CMD_FAN1_SPEED     = 8'h85;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int RESTORE_ENABLE_BIT = 0;
	localparam int RESTORE_MODE_BIT   = 1;
	localparam int WD_ENABLE_BIT      = 7;
	localparam int FAN_TANDEM_BIT     = 7;
	localparam int ALIVE_OFF_BIT      = 0;

	localparam logic [7:0] DEF_FAN_MGMT      = 8'hA4;
	localparam logic [7:0] DEF_REMOTE_SD     = 8'h1E;
	localparam logic [7:0] DEF_REMOTE_DETECT = 8'h00;
	localparam logic [7:0] DEF_PWR_RESTORE   = 8'h00;
	localparam logic [7:0] DEF_WD_CTRL       = 8'h00;
	localparam logic [7:0] DEF_WD_TIMEOUT    = 8'h78;
	localparam logic [7:0] DEF_WD_REBOOT     = 8'h78;
	localparam logic [7:0] DEF_WD_POWER_OFF  = 8'h0A;
	localparam logic [7:0] DEF_BUS_ADDR      = 8'h5A;
	localparam logic [7:0] DEF_FAN_SPEED     = 8'h64;
	localparam logic [7:0] FAN_MAX_PCT       = 8'h64;
	localparam logic [7:0] READ_ALL_ONES     = 8'hFF;
	localparam logic [7:0] DEF_BLOCK_LEN     = 8'h0A;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SECOND_NS     = 1000000000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       stb;
		logic [7:0] addr;
		logic [7:0] data;
	} hpw_wr_t;

	typedef struct packed {
		logic [7:0] base;
		logic [7:0] idx;
	} hpw_rd_t;

	typedef struct packed {
		logic [7:0] fan_mgmt;
		logic [7:0] remote_shutdown_delay;
		logic [7:0] remote_shutdown_detect_delay;
		logic [7:0] power_restore_control;
		logic [7:0] watchdog_control;
		logic [7:0] watchdog_timeout_delay;
		logic [7:0] watchdog_reboot_delay;
		logic [7:0] watchdog_power_off_delay;
		logic [7:0] bus_target_address;
		logic [7:0] fan0_speed;
		logic [7:0] fan1_speed;
	} hpw_cfg_t;

	localparam hpw_cfg_t DEF_CFG = '{
		fan_mgmt:                     DEF_FAN_MGMT,
		remote_shutdown_delay:        DEF_REMOTE_SD,
		remote_shutdown_detect_delay: DEF_REMOTE_DETECT,
		power_restore_control:        DEF_PWR_RESTORE,
		watchdog_control:             DEF_WD_CTRL,
		watchdog_timeout_delay:       DEF_WD_TIMEOUT,
		watchdog_reboot_delay:        DEF_WD_REBOOT,
		watchdog_power_off_delay:     DEF_WD_POWER_OFF,
		bus_target_address:           DEF_BUS_ADDR,
		fan0_speed:                   DEF_FAN_SPEED,
		fan1_speed:                   DEF_FAN_SPEED
	};

endpackage

// ---- hpw_power_watchdog.sv ----
/*
 * Host power watchdog controller: register map, remote shutdown, power
 * restore after supply failure, keep-alive watchdog and fan speed settings.
 * Assumes supply_ok and the I2C pins are asynchronous to mclk.
 */
// Contract
// R01: Alive drop: power off after remote delay
// R02: Alive return cancels pending power removal
// R03: Restore enabled: detect delay before dropping indication
// R04: Restore register bits one, zero; reset zero
// R05: Restore disabled: never auto power-on
// R06: Mode zero: restore only if was on
// R07: Mode one: always restore power
// R08: Watchdog enable bit seven, attempts 0-127
// R09: No keep-alive within timeout: power-cycle
// R10: After reboot wait reboot delay
// R11: Power-cycle off time from register
// R12: Own bus address held in register
// R13: Write 0x80 restores defaults; read gives block
// R14: Keep-alive write restarts count; reads ones
// R15: Fan speeds 0-100 writable and readable
// R16: Commands share bus, trigger actions
// R17: Tandem: fan 1 writes ignored
// R18: Alive command bit zero; reads ones
// R19: Delays count whole seconds from tick
`timescale 1ns/1ns

module hpw_power_watchdog #(
	parameter int SECOND_CYCLES = hpw_pkg::SECOND_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic supply_ok,
	output logic      host_power_on,
	output logic      alive_indication,
	output logic [7:0] fan0_duty,
	output logic [7:0] fan1_duty
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		HPW_P_OFF, HPW_P_ON, HPW_P_DETECT, HPW_P_SHUTDOWN, HPW_P_CYCLE
	} hpw_pwr_st_t;

	typedef enum logic [1:0] {
		HPW_W_IDLE, HPW_W_RUN, HPW_W_REBOOT, HPW_W_SPENT
	} hpw_wd_st_t;

	typedef struct packed {
		hpw_pkg::hpw_cfg_t cfg;
		logic [2:0]        supply_sync;
		logic              alive_cmd;
		logic              alive_out;
		hpw_pwr_st_t       pst;
		logic [7:0]        pcnt;
		logic              was_on;
		hpw_wd_st_t        wst;
		logic [7:0]        wcnt;
		logic [6:0]        attempts;
		logic [31:0]       tick_cnt;
		logic              tick;
		logic              power;
		logic [7:0]        fan0;
		logic [7:0]        fan1;
	} hpw_state_t;

	hpw_state_t s_ff;
	hpw_state_t nxt_s;

	hpw_pkg::hpw_wr_t wr;
	hpw_pkg::hpw_rd_t rd;
	logic [7:0]       rd_data;
	logic [7:0]       rd_addr;
	logic             i2c_oe;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	function automatic logic [7:0] cfg_read(input hpw_pkg::hpw_cfg_t c, input logic [7:0] a);
		logic [7:0] v;
		v = hpw_pkg::READ_ALL_ONES;
		case (a)
		hpw_pkg::REG_FAN_MGMT:      v = c.fan_mgmt;
		hpw_pkg::REG_REMOTE_SD:     v = c.remote_shutdown_delay;
		hpw_pkg::REG_REMOTE_DETECT: v = c.remote_shutdown_detect_delay;
		hpw_pkg::REG_PWR_RESTORE:   v = c.power_restore_control;
		hpw_pkg::REG_WD_CTRL:       v = c.watchdog_control;
		hpw_pkg::REG_WD_TIMEOUT:    v = c.watchdog_timeout_delay;
		hpw_pkg::REG_WD_REBOOT:     v = c.watchdog_reboot_delay;
		hpw_pkg::REG_WD_POWER_OFF:  v = c.watchdog_power_off_delay;
		hpw_pkg::REG_BUS_ADDR:      v = c.bus_target_address;
		hpw_pkg::CMD_FAN0_SPEED:    v = c.fan0_speed; // R15
		hpw_pkg::CMD_FAN1_SPEED:    v = c.fan1_speed; // R15
		default:                    v = hpw_pkg::READ_ALL_ONES; // R14 R18
		endcase
		return v;
	endfunction

	function automatic logic [7:0] clamp_pct(input logic [7:0] d);
		return (d > hpw_pkg::FAN_MAX_PCT) ? hpw_pkg::FAN_MAX_PCT : d;
	endfunction

	assign rd_addr = rd.base + rd.idx;

	always_comb begin
		if (rd.base == hpw_pkg::CMD_RESET_DEFAULTS) begin
			// Default block walks the configuration window byte by byte
			if (rd.idx < hpw_pkg::DEF_BLOCK_LEN) begin
				rd_data = cfg_read(hpw_pkg::DEF_CFG, hpw_pkg::REG_FAN_MGMT + rd.idx); // R13
			end else begin
				rd_data = hpw_pkg::READ_ALL_ONES;
			end
		end else begin
			rd_data = cfg_read(s_ff.cfg, rd_addr);
		end
	end

	hpw_i2c_target u_i2c (
		.mclk    (mclk),
		.rst     (rst),
		.ce      (ce),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.my_addr (s_ff.cfg.bus_target_address[6:0]),
		.rd_data (rd_data),
		.wr      (wr),
		.rd      (rd),
		.sda_oe  (i2c_oe)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic supply_fall;
	logic supply_rise;
	logic keep_alive;
	logic alive_fall;
	logic alive_rise;
	logic wd_on;
	logic restore_en;

	assign supply_fall = ~s_ff.supply_sync[1] & s_ff.supply_sync[2];
	assign supply_rise = s_ff.supply_sync[1] & ~s_ff.supply_sync[2];
	assign keep_alive  = wr.stb && wr.addr == hpw_pkg::CMD_KEEP_ALIVE; // R14
	assign alive_fall  = wr.stb && wr.addr == hpw_pkg::CMD_ALIVE &&
		wr.data[hpw_pkg::ALIVE_OFF_BIT] && s_ff.alive_cmd;
	assign alive_rise  = wr.stb && wr.addr == hpw_pkg::CMD_ALIVE &&
		!wr.data[hpw_pkg::ALIVE_OFF_BIT];
	// A zero timeout also disables the watchdog
	assign wd_on       = s_ff.cfg.watchdog_control[hpw_pkg::WD_ENABLE_BIT] &&
		s_ff.cfg.watchdog_timeout_delay != 8'h00; // R08
	assign restore_en  = s_ff.cfg.power_restore_control[hpw_pkg::RESTORE_ENABLE_BIT];

	always_comb begin
		nxt_s             = s_ff;
		nxt_s.supply_sync = {s_ff.supply_sync[1:0], supply_ok};

		// One-second tick shared by all delays
		nxt_s.tick = 1'b0;
		if (s_ff.tick_cnt >= 32'(SECOND_CYCLES - 1)) begin
			nxt_s.tick_cnt = 32'h0000_0000;
			nxt_s.tick     = 1'b1; // R19
		end else begin
			nxt_s.tick_cnt = s_ff.tick_cnt + 32'h0000_0001;
		end
		if (s_ff.tick && s_ff.pcnt != 8'h00) begin
			nxt_s.pcnt = s_ff.pcnt - 8'h01; // R19
		end
		if (s_ff.tick && s_ff.wcnt != 8'h00) begin
			nxt_s.wcnt = s_ff.wcnt - 8'h01; // R19
		end

		// Register and command writes
		if (wr.stb) begin
			case (wr.addr)
			hpw_pkg::REG_FAN_MGMT:      nxt_s.cfg.fan_mgmt = wr.data;
			hpw_pkg::REG_REMOTE_SD:     nxt_s.cfg.remote_shutdown_delay = wr.data;
			hpw_pkg::REG_REMOTE_DETECT: nxt_s.cfg.remote_shutdown_detect_delay = wr.data;
			hpw_pkg::REG_PWR_RESTORE:   nxt_s.cfg.power_restore_control = {6'h00, wr.data[1:0]}; // R04
			hpw_pkg::REG_WD_CTRL:       nxt_s.cfg.watchdog_control = wr.data; // R08
			hpw_pkg::REG_WD_TIMEOUT:    nxt_s.cfg.watchdog_timeout_delay = wr.data;
			hpw_pkg::REG_WD_REBOOT:     nxt_s.cfg.watchdog_reboot_delay = wr.data;
			hpw_pkg::REG_WD_POWER_OFF:  nxt_s.cfg.watchdog_power_off_delay = wr.data;
			hpw_pkg::REG_BUS_ADDR:      nxt_s.cfg.bus_target_address = wr.data; // R12
			hpw_pkg::CMD_RESET_DEFAULTS: nxt_s.cfg = hpw_pkg::DEF_CFG; // R13 R16
			hpw_pkg::CMD_FAN0_SPEED:    nxt_s.cfg.fan0_speed = clamp_pct(wr.data); // R15
			hpw_pkg::CMD_FAN1_SPEED: begin
				if (!s_ff.cfg.fan_mgmt[hpw_pkg::FAN_TANDEM_BIT]) begin
					nxt_s.cfg.fan1_speed = clamp_pct(wr.data); // R15 R17
				end
			end
			default: begin
				nxt_s.cfg = nxt_s.cfg;
			end
			endcase
		end
		if (alive_rise) begin
			nxt_s.alive_cmd = 1'b1; // R18
			nxt_s.alive_out = 1'b1;
		end else if (alive_fall) begin
			nxt_s.alive_cmd = 1'b0; // R18
		end

		// Fans follow fan 0 in tandem
		nxt_s.fan0 = s_ff.cfg.fan0_speed;
		nxt_s.fan1 = s_ff.cfg.fan_mgmt[hpw_pkg::FAN_TANDEM_BIT] ?
			s_ff.cfg.fan0_speed : s_ff.cfg.fan1_speed; // R17

		// Power sequencing
		case (s_ff.pst)
		HPW_P_OFF: begin
			nxt_s.power = 1'b0;
			if (supply_rise && restore_en &&
			    (s_ff.cfg.power_restore_control[hpw_pkg::RESTORE_MODE_BIT] || s_ff.was_on)) begin
				nxt_s.pst   = HPW_P_ON; // R05 R06 R07
				nxt_s.power = 1'b1;
			end
		end
		HPW_P_ON: begin
			if (alive_fall) begin
				if (restore_en) begin
					nxt_s.pst  = HPW_P_DETECT; // R03
					nxt_s.pcnt = s_ff.cfg.remote_shutdown_detect_delay;
				end else begin
					nxt_s.pst       = HPW_P_SHUTDOWN; // R01
					nxt_s.pcnt      = s_ff.cfg.remote_shutdown_delay;
					nxt_s.alive_out = 1'b0;
				end
			end
		end
		HPW_P_DETECT: begin
			if (alive_rise) begin
				nxt_s.pst = HPW_P_ON; // R02
			end else if (s_ff.pcnt == 8'h00) begin
				nxt_s.pst       = HPW_P_SHUTDOWN; // R03
				nxt_s.pcnt      = s_ff.cfg.remote_shutdown_delay;
				nxt_s.alive_out = 1'b0;
			end
		end
		HPW_P_SHUTDOWN: begin
			if (alive_rise) begin
				nxt_s.pst = HPW_P_ON; // R02
			end else if (s_ff.pcnt == 8'h00) begin
				nxt_s.pst   = HPW_P_OFF; // R01
				nxt_s.power = 1'b0;
			end
		end
		HPW_P_CYCLE: begin
			nxt_s.power = 1'b0;
			if (s_ff.pcnt == 8'h00) begin
				nxt_s.pst   = HPW_P_ON; // R11
				nxt_s.power = 1'b1;
			end
		end
		default: begin
			nxt_s.pst = HPW_P_OFF;
		end
		endcase

		// Watchdog
		case (s_ff.wst)
		HPW_W_IDLE: begin
			if (wd_on && s_ff.pst == HPW_P_ON) begin
				nxt_s.wst      = HPW_W_RUN;
				nxt_s.wcnt     = s_ff.cfg.watchdog_timeout_delay;
				nxt_s.attempts = 7'h00;
			end
		end
		HPW_W_RUN, HPW_W_REBOOT, HPW_W_SPENT: begin
			if (!wd_on || s_ff.pst == HPW_P_OFF) begin
				nxt_s.wst = HPW_W_IDLE;
			end else if (s_ff.wst == HPW_W_SPENT) begin
				nxt_s.wst = HPW_W_SPENT; // R08
			end else if (s_ff.pst == HPW_P_CYCLE) begin
				// Reboot window restarts while power is held off
				nxt_s.wcnt = s_ff.cfg.watchdog_reboot_delay; // R10
			end else if (keep_alive) begin
				nxt_s.wst      = HPW_W_RUN; // R14
				nxt_s.wcnt     = s_ff.cfg.watchdog_timeout_delay;
				nxt_s.attempts = 7'h00;
			end else if (s_ff.wcnt == 8'h00 && s_ff.pst == HPW_P_ON) begin
				if (s_ff.wst == HPW_W_RUN ||
				    s_ff.attempts < s_ff.cfg.watchdog_control[6:0]) begin
					nxt_s.wst      = HPW_W_REBOOT; // R09 R10
					nxt_s.attempts = (s_ff.wst == HPW_W_RUN) ? 7'h00 : s_ff.attempts + 7'h01;
					nxt_s.pst      = HPW_P_CYCLE; // R11
					nxt_s.pcnt     = s_ff.cfg.watchdog_power_off_delay;
					nxt_s.power    = 1'b0;
				end else begin
					// Attempts used up: stay quiet until enable or power changes
					nxt_s.wst = HPW_W_SPENT;
				end
			end
		end
		default: begin
			nxt_s.wst = HPW_W_IDLE;
		end
		endcase

		// Supply failure overrides power, watchdog and alive state
		if (supply_fall) begin
			nxt_s.was_on    = s_ff.power;
			nxt_s.pst       = HPW_P_OFF;
			nxt_s.power     = 1'b0;
			nxt_s.wst       = HPW_W_IDLE;
			nxt_s.alive_cmd = 1'b0;
			nxt_s.alive_out = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_ff     <= '0;
			s_ff.cfg <= hpw_pkg::DEF_CFG;
			s_ff.pst <= HPW_P_OFF;
			s_ff.wst <= HPW_W_IDLE;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sda_out          = 1'b0;
	assign sda_oe           = i2c_oe;
	assign host_power_on    = s_ff.power;
	assign alive_indication = s_ff.alive_out;
	assign fan0_duty        = s_ff.fan0;
	assign fan1_duty        = s_ff.fan1;

endmodule

// ---- hpw_power_watchdog_assertions.sv ----
/*
 * Port assertions for the power watchdog top, attached by bind.
 * Assumes one clock domain and the top's ports only.
 */
`timescale 1ns/1ns

module hpw_power_watchdog_assertions #(
	parameter int SECOND_CYCLES = 1000
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       supply_ok,
	input wire logic       host_power_on,
	input wire logic       alive_indication,
	input wire logic [7:0] fan0_duty,
	input wire logic [7:0] fan1_duty
);
	// -----------------------------------------
	// Off-time counter
	// -----------------------------------------
	// Saturates so a long idle never wraps
	int off_cnt_ff;

	always_ff @(posedge mclk) begin
		if (host_power_on)
			off_cnt_ff <= 0;
		else if (off_cnt_ff != SECOND_CYCLES)
			off_cnt_ff <= off_cnt_ff + 1;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_supply_lost;
		!supply_ok [*8];
	endsequence

	AST_SDA_LOW: assert property (sda_out == 1'b0)
		else $error("sda_out high");
	AST_RESET: assert property (disable iff (1'b0)
		rst |=> !host_power_on && !alive_indication && !sda_oe)
		else $error("output set after reset");
	AST_FAN_RANGE: assert property (
		fan0_duty <= hpw_pkg::FAN_MAX_PCT && fan1_duty <= hpw_pkg::FAN_MAX_PCT)
		else $error("fan duty above limit");
	AST_PWR_SUPPLY: assert property (
		$rose(host_power_on) |-> supply_ok && $past(supply_ok, 2))
		else $error("power on without supply");
	AST_LOSS_OFF: assert property (s_supply_lost |-> !host_power_on)
		else $error("power kept in supply loss");
	AST_OFF_MIN: assert property ($rose(host_power_on) |-> off_cnt_ff >= 8)
		else $error("power off too briefly");
	AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("sda pulled with scl high");
	AST_CE_HOLD: assert property (
		!ce |=> $stable(host_power_on) && $stable(alive_indication))
		else $error("state moved with ce low");
endmodule

bind hpw_power_watchdog hpw_power_watchdog_assertions #(
	.SECOND_CYCLES(SECOND_CYCLES)
) u_hpw_chk (
	.mclk(mclk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .supply_ok(supply_ok),
	.host_power_on(host_power_on), .alive_indication(alive_indication),
	.fan0_duty(fan0_duty), .fan1_duty(fan1_duty)
);

// ---- hpw_power_watchdog_bench.sv ----
/*
 * Self-checking bench for the power watchdog controller.
 * Assumes the host model as bus master and a pull-up on SDA.
 */
`timescale 1ns/1ns

module hpw_power_watchdog_bench;
	localparam int LIMIT = 80000;

	logic       mclk, rst, ce, scl_in, sda_low, sda_out, sda_oe, supply_ok;
	logic       host_power_on, alive_indication;
	logic [7:0] fan0_duty, fan1_duty, q;
	logic [6:0] dev;
	int         failures, num_checks, cyc;
	wire        sda_in = !(sda_low | sda_oe);
	wire  [7:0] pw = {7'h00, host_power_on};
	wire  [7:0] al = {7'h00, alive_indication};

	// Location, write data, read-back
	logic [23:0] rows [10] = '{24'h34FF03, 24'h358282, 24'h320505, 24'h84C864,
		24'h843232, 24'h851064, 24'h8200FF, 24'h8100FF, 24'h8301FF, 24'h2055FF};
	// Restore mode, expected power after a dip
	logic [8:0] prow [5] = '{9'h007, 9'h000, 9'h002, 9'h007, 9'h003};

	hpw_power_watchdog #(.SECOND_CYCLES(1000)) u_hpw_power_watchdog (
		.mclk, .rst, .ce, .scl_in, .sda_in, .sda_out, .sda_oe, .supply_ok,
		.host_power_on, .alive_indication, .fan0_duty, .fan1_duty);
	hpw_host_model u_hpw_host_model (.mclk, .sda(sda_in), .scl(scl_in), .sda_low);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = !mclk;
	end

	task automatic close_out();
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_hpw_host_model.wr(dev, a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		u_hpw_host_model.rd(dev, a, q);
		chk(q, exp);
	endtask

	task automatic dip();
		supply_ok <= 1'b0;
		repeat (40) @(posedge mclk);
		supply_ok <= 1'b1;
	endtask

	task automatic wait_pw(input logic [7:0] v, input int n);
		for (int i = 0; i < n && pw !== v; i++)
			@(posedge mclk);
		chk(pw, v);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			$display("ERROR %0t cycle limit reached", $time);
			close_out();
		end
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		supply_ok = 1'b1;
		dev = 7'h5A;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (5) @(posedge mclk);
		chk(pw | al, 8'h00);
		rd_chk(8'h35, 8'h00);
		rd_chk(8'h39, 8'h5A);
		for (int i = 0; i < 10; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd_chk(rows[i][23:16], rows[i][7:0]);
		end
		chk(fan0_duty, 8'h32);
		chk(fan1_duty, 8'h32);
		wr(8'h80, 8'h00);
		rd_chk(8'h34, 8'h00);
		rd_chk(8'h80, hpw_pkg::DEF_FAN_MGMT);
		// -----------------------------------------
		// Restore after supply dips
		// -----------------------------------------
		for (int i = 0; i < 5; i++) begin
			wr(8'h34, prow[i][8:1]);
			dip();
			repeat (300) @(posedge mclk);
			chk(pw, {7'h00, prow[i][0]});
		end
		// -----------------------------------------
		// Remote shutdown: cancelled, then completed
		// -----------------------------------------
		wr(8'h32, 8'h03);
		wr(8'h33, 8'h02);
		wr(8'h83, 8'h00);
		chk(al, 8'h01);
		wr(8'h83, 8'h01);
		repeat (500) @(posedge mclk);
		chk(al, 8'h01);
		wr(8'h83, 8'h00);
		repeat (6000) @(posedge mclk);
		chk(pw & al, 8'h01);
		wr(8'h83, 8'h01);
		repeat (6000) @(posedge mclk);
		chk(pw | al, 8'h00);
		// -----------------------------------------
		// Watchdog cycles, then attempts run out
		// -----------------------------------------
		wr(8'h34, 8'h03);
		dip();
		wait_pw(8'h01, 300);
		wr(8'h36, 8'h03);
		wr(8'h37, 8'h02);
		wr(8'h38, 8'h02);
		wr(8'h35, 8'h81);
		repeat (4) begin
			repeat (1000) @(posedge mclk);
			wr(8'h82, 8'h00);
		end
		chk(pw, 8'h01);
		wait_pw(8'h00, 4000);
		repeat (900) @(posedge mclk);
		chk(pw, 8'h00);
		wait_pw(8'h01, 1200);
		wait_pw(8'h00, 2500);
		wait_pw(8'h01, 2500);
		repeat (4000) @(posedge mclk);
		chk(pw, 8'h01);
		wr(8'h39, 8'h21);
		dev = 7'h21;
		rd_chk(8'h39, 8'h21);
		u_hpw_host_model.rd(7'h5A, 8'h39, q);
		chk(q, 8'hFF);
		ce <= 1'b0;
		repeat (10) @(posedge mclk);
		ce <= 1'b1;
		close_out();
	end
endmodule
